// >>> verilog/dca_map.svh
`ifndef DCA_MAP_SVH
`define DCA_MAP_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define DCA_OFF_POLE      8'h00
`define DCA_OFF_CURR      8'h04
`define DCA_OFF_RATED     8'h08
`define DCA_OFF_PEAKDUR   8'h0c
`define DCA_OFF_SUBMODE   8'h10
`define DCA_OFF_REDUCE    8'h14
`define DCA_OFF_ENC       8'h18
`define DCA_OFF_OPMODE    8'h1c
`define DCA_OFF_CTRL      8'h20
`define DCA_OFF_STATUS    8'h24
`define DCA_OFF_PROG      8'h28
`define DCA_OFF_NET       8'h2c
// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define DCA_RST_POLE      32'h0000_0032
`define DCA_RST_PEAKDUR   32'h0000_0064
`define DCA_RST_SUBMODE   32'h0000_0008
`define DCA_SUB_STEP      32'h0000_0008
`define DCA_SUB_STEP_BRK  32'h0000_000c
`define DCA_SUB_BLDC      32'h0000_0041
`define DCA_SUB_BLDC_BRK  32'h0000_0044
`define DCA_MODE_AUTOSET  8'hfe
`define DCA_CW_START_BIT  4
`define DCA_SW_IDX_BIT    10
`define DCA_SW_DONE_BIT   12
`define DCA_TCP_PORT      16'h01f6
`define DCA_FN_ENCAP      8'h2b
`define DCA_TYPE_READ     8'h0d
`define DCA_RSP_LEN       8'h0f
`define DCA_RSP_TAIL      8'h06
`define DCA_REQ_BYTES     19
`define DCA_RSP_BYTES     20
// ----------------------------------------
// timing
// ----------------------------------------
`define DCA_CLK_MHZ       100
`define DCA_STEP_US       10
`define DCA_STEP_CYC      (`DCA_STEP_US * `DCA_CLK_MHZ)
`define DCA_DHCP_WAIT_MS  1000
`define DCA_DHCP_WAIT_CYC (`DCA_DHCP_WAIT_MS * 1000 * `DCA_CLK_MHZ)
`endif

// >>> verilog/dca_pkg.sv
package dca_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FWD,
        ST_REV,
        ST_EDGE,
        ST_DONE
    } dca_state_t;
endpackage

// >>> verilog/dca_drive_config.sv
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "dca_map.svh"
// Behaviour
// - tcp port 502 only, one client
// - no crc bytes on tcp frames
// - function 2Bh reaches only object 6041h (statusword)
// - answer length 0F, echo, statusword, 06
// - 2030h holds pole pairs, default 50
// - 2031h holds rated or peak current
// - 203Bh rated current, peak duration 100ms
// - submode 08h stepper, 0Ch with brake
// - submode 41h brushless, 44h with brake
// - 2037h reduced standstill current in open loop
// - encoder codes 0..3 select interface
// - opmode FEh preselects auto setup
// - controlword bit 4 starts auto setup
// - statusword bit 12 marks setup done
// - statusword bit 10 reports index found
// - closed loop only after auto setup
// - setup invalidates coordinates until restart
// - measurement reversed, edges re-evaluated
// - dhcp by default, else self address
module dca_drive_config #(
    parameter int STEP_CYC      = `DCA_STEP_CYC,
    parameter int DHCP_WAIT_CYC = `DCA_DHCP_WAIT_CYC
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        ce,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        conn_req,
    input  wire logic        conn_close,
    input  wire logic [15:0] conn_port,
    output logic             conn_active,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_last,
    output logic             rx_ready,
    output logic             tx_valid,
    output logic [7:0]       tx_data,
    output logic             tx_last,
    input  wire logic        tx_ready,
    input  wire logic        dhcp_offer,
    output logic             self_assigned_address,
    input  wire logic        index_pulse,
    output logic             motor_is_bldc,
    output logic             brake_en,
    output logic             standstill_red_en,
    output logic [1:0]       enc_sel,
    output logic             closed_loop_ok,
    output logic             coord_valid
);
    if (STEP_CYC < 1 || DHCP_WAIT_CYC < 1) begin : g_bad_counts
        $error("dca: counts must be at least one");
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [31:0] pole_q, curr_q, rated_q, peakdur_q, submode_q, reduce_q, enc_q, prog_q;
    logic [7:0]  opmode_q;
    logic [15:0] ctrl_q;
    logic [15:0] status;
    logic        setup_ok_q, done_q, idx_found_q, coord_valid_q, self_addr_q, conn_q;
    dca_pkg::dca_state_t st_q;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a <= `DCA_OFF_NET) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            old[i*8 +: 8] = be[i] ? d[i*8 +: 8] : old[i*8 +: 8];
        end
        merge = old;
    endfunction

    // ----------------------------------------
    // axi4-lite slave
    // ----------------------------------------
    logic wr_go;
    logic rd_go;
    assign wr_go         = ce && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign rd_go         = ce && s_axi_arvalid && !s_axi_rvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_arready = rd_go;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else if (ce) begin
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(s_axi_awaddr) ? 2'b00 : 2'b10;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // object dictionary values, written only from software
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pole_q    <= `DCA_RST_POLE;
            curr_q    <= 32'h0000_0000;
            rated_q   <= 32'h0000_0000;
            peakdur_q <= `DCA_RST_PEAKDUR;
            submode_q <= `DCA_RST_SUBMODE;
            reduce_q  <= 32'h0000_0000;
            enc_q     <= 32'h0000_0000;
            prog_q    <= 32'h0000_0000;
            opmode_q  <= 8'h00;
            ctrl_q    <= 16'h0000;
        end else if (wr_go) begin
            if (s_axi_awaddr == `DCA_OFF_POLE) begin
                pole_q <= merge(pole_q, s_axi_wdata, s_axi_wstrb);
            end else if (s_axi_awaddr == `DCA_OFF_CURR) begin
                curr_q <= merge(curr_q, s_axi_wdata, s_axi_wstrb);
            end else if (s_axi_awaddr == `DCA_OFF_RATED) begin
                rated_q <= merge(rated_q, s_axi_wdata, s_axi_wstrb);
            end else if (s_axi_awaddr == `DCA_OFF_PEAKDUR) begin
                peakdur_q <= merge(peakdur_q, s_axi_wdata, s_axi_wstrb);
            end else if (s_axi_awaddr == `DCA_OFF_SUBMODE) begin
                submode_q <= merge(submode_q, s_axi_wdata, s_axi_wstrb);
            end else if (s_axi_awaddr == `DCA_OFF_REDUCE) begin
                reduce_q <= merge(reduce_q, s_axi_wdata, s_axi_wstrb);
            end else if (s_axi_awaddr == `DCA_OFF_ENC) begin
                enc_q <= merge(enc_q, s_axi_wdata, s_axi_wstrb);
            end else if (s_axi_awaddr == `DCA_OFF_OPMODE && s_axi_wstrb[0]) begin
                opmode_q <= s_axi_wdata[7:0];
            end else if (s_axi_awaddr == `DCA_OFF_CTRL) begin
                ctrl_q <= 16'(merge({16'h0000, ctrl_q}, s_axi_wdata, s_axi_wstrb));
            end else if (s_axi_awaddr == `DCA_OFF_PROG) begin
                prog_q <= merge(prog_q, s_axi_wdata, s_axi_wstrb);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'b00;
        end else if (ce) begin
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
                if (s_axi_araddr == `DCA_OFF_POLE) begin
                    s_axi_rdata <= pole_q;
                end else if (s_axi_araddr == `DCA_OFF_CURR) begin
                    s_axi_rdata <= curr_q;
                end else if (s_axi_araddr == `DCA_OFF_RATED) begin
                    s_axi_rdata <= rated_q;
                end else if (s_axi_araddr == `DCA_OFF_PEAKDUR) begin
                    s_axi_rdata <= peakdur_q;
                end else if (s_axi_araddr == `DCA_OFF_SUBMODE) begin
                    s_axi_rdata <= submode_q;
                end else if (s_axi_araddr == `DCA_OFF_REDUCE) begin
                    s_axi_rdata <= reduce_q;
                end else if (s_axi_araddr == `DCA_OFF_ENC) begin
                    s_axi_rdata <= enc_q;
                end else if (s_axi_araddr == `DCA_OFF_OPMODE) begin
                    s_axi_rdata <= {24'h00_0000, opmode_q};
                end else if (s_axi_araddr == `DCA_OFF_CTRL) begin
                    s_axi_rdata <= {16'h0000, ctrl_q};
                end else if (s_axi_araddr == `DCA_OFF_STATUS) begin
                    s_axi_rdata <= {16'h0000, status};
                end else if (s_axi_araddr == `DCA_OFF_PROG) begin
                    s_axi_rdata <= prog_q;
                end else if (s_axi_araddr == `DCA_OFF_NET) begin
                    s_axi_rdata <= {28'h000_0000, coord_valid_q, setup_ok_q, self_addr_q, conn_q};
                end else begin
                    s_axi_rdata <= 32'h0000_0000;
                end
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // drive configuration decode
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            motor_is_bldc     <= 1'b0;
            brake_en          <= 1'b0;
            standstill_red_en <= 1'b1;
            enc_sel           <= 2'b00;
        end else if (ce) begin
            motor_is_bldc     <= (submode_q == `DCA_SUB_BLDC) || (submode_q == `DCA_SUB_BLDC_BRK);
            brake_en          <= (submode_q == `DCA_SUB_STEP_BRK) || (submode_q == `DCA_SUB_BLDC_BRK);
            standstill_red_en <= (submode_q == `DCA_SUB_STEP) || (submode_q == `DCA_SUB_STEP_BRK);
            enc_sel           <= enc_q[1:0];
        end
    end

    // ----------------------------------------
    // auto setup sequencer
    // ----------------------------------------
    logic        op_enabled;
    logic        start_prev_q;
    logic        start_go;
    logic [31:0] step_cnt_q;
    logic        step_end;
    assign op_enabled = (ctrl_q[3:0] == 4'hf);
    // a running user program would fight the measurement, so it blocks the start
    assign start_go   = ce && (st_q == dca_pkg::ST_IDLE || st_q == dca_pkg::ST_DONE) &&
                        (opmode_q == `DCA_MODE_AUTOSET) && op_enabled && !prog_q[0] &&
                        ctrl_q[`DCA_CW_START_BIT] && !start_prev_q;
    assign step_end   = (step_cnt_q == 32'(STEP_CYC - 1));

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_q         <= dca_pkg::ST_IDLE;
            step_cnt_q   <= 32'h0000_0000;
            start_prev_q <= 1'b0;
        end else if (ce) begin
            start_prev_q <= ctrl_q[`DCA_CW_START_BIT];
            step_cnt_q   <= (st_q == dca_pkg::ST_IDLE || st_q == dca_pkg::ST_DONE || step_end) ?
                            32'h0000_0000 : step_cnt_q + 32'h0000_0001;
            case (st_q)
                dca_pkg::ST_IDLE, dca_pkg::ST_DONE: begin
                    if (start_go) st_q <= dca_pkg::ST_FWD;
                end
                dca_pkg::ST_FWD: begin
                    if (step_end) st_q <= dca_pkg::ST_REV;
                end
                dca_pkg::ST_REV: begin
                    if (step_end) st_q <= dca_pkg::ST_EDGE;
                end
                dca_pkg::ST_EDGE: begin
                    if (step_end) st_q <= dca_pkg::ST_DONE;
                end
                default: st_q <= dca_pkg::ST_IDLE;
            endcase
        end
    end

    // coordinates stay invalid until the next reset; homing does not help
    always_ff @(posedge clk) begin
        if (!nrst) begin
            done_q        <= 1'b0;
            idx_found_q   <= 1'b0;
            setup_ok_q    <= 1'b0;
            coord_valid_q <= 1'b1;
        end else if (ce) begin
            if (start_go) begin
                done_q      <= 1'b0;
                idx_found_q <= 1'b0;
            end else if (st_q != dca_pkg::ST_IDLE && st_q != dca_pkg::ST_DONE && index_pulse) begin
                idx_found_q <= 1'b1;
            end
            if (st_q == dca_pkg::ST_EDGE && step_end) begin
                done_q        <= 1'b1;
                setup_ok_q    <= 1'b1;
                coord_valid_q <= 1'b0;
            end
        end
    end

    assign status = {3'b000, done_q, 1'b0, idx_found_q && done_q, 7'h00, op_enabled, op_enabled, op_enabled};
    assign closed_loop_ok = setup_ok_q;
    assign coord_valid    = coord_valid_q;

    // ----------------------------------------
    // network address and connection
    // ----------------------------------------
    logic [31:0] dhcp_cnt_q;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            dhcp_cnt_q  <= 32'h0000_0000;
            self_addr_q <= 1'b0;
        end else if (ce) begin
            if (dhcp_offer) begin
                dhcp_cnt_q  <= 32'h0000_0000;
                self_addr_q <= 1'b0;
            end else if (dhcp_cnt_q == 32'(DHCP_WAIT_CYC - 1)) begin
                self_addr_q <= 1'b1;
            end else begin
                dhcp_cnt_q <= dhcp_cnt_q + 32'h0000_0001;
            end
        end
    end
    assign self_assigned_address = self_addr_q;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            conn_q <= 1'b0;
        end else if (ce) begin
            if (conn_close) begin
                conn_q <= 1'b0;
            end else if (conn_req && !conn_q && conn_port == `DCA_TCP_PORT) begin
                conn_q <= 1'b1;
            end
        end
    end
    assign conn_active = conn_q;

    // ----------------------------------------
    // frame engine
    // ----------------------------------------
    logic [7:0]  req_q [0:`DCA_REQ_BYTES-1];
    logic [4:0]  rx_cnt_q;
    logic [4:0]  tx_idx_q;
    logic        tx_busy_q;
    logic [15:0] sw_snap_q;
    logic        req_ok;
    logic        rx_take;
    logic        tx_step;

    // one request at a time; no crc is ever expected or sent
    assign rx_ready = conn_q && !tx_busy_q;
    assign rx_take  = ce && rx_valid && rx_ready;
    assign tx_step  = ce && tx_busy_q && tx_ready;
    assign tx_valid = tx_busy_q;
    assign req_ok   = (rx_cnt_q == 5'(`DCA_REQ_BYTES - 1)) && (req_q[7] == `DCA_FN_ENCAP) &&
                      (req_q[8] == `DCA_TYPE_READ) && (req_q[12] == 8'h60) && (req_q[13] == 8'h41) &&
                      (rx_data == 8'h02);

    function automatic logic [7:0] rsp_byte(input logic [4:0] i, input logic [15:0] sw);
        if (i < 5'd4) begin
            rsp_byte = req_q[i];
        end else if (i == 5'd4) begin
            rsp_byte = `DCA_RSP_LEN;
        end else if (i == 5'd5) begin
            rsp_byte = 8'h00;
        end else if (i < 5'd17) begin
            rsp_byte = req_q[i + 5'd1];
        end else if (i == 5'd17) begin
            rsp_byte = sw[7:0];
        end else if (i == 5'd18) begin
            rsp_byte = sw[15:8];
        end else begin
            rsp_byte = `DCA_RSP_TAIL;
        end
    endfunction

    always_ff @(posedge clk) begin
        if (rx_take) begin
            req_q[rx_cnt_q] <= rx_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rx_cnt_q  <= 5'd0;
            tx_busy_q <= 1'b0;
            tx_idx_q  <= 5'd0;
            tx_data   <= 8'h00;
            tx_last   <= 1'b0;
            sw_snap_q <= 16'h0000;
        end else if (ce) begin
            if (rx_take) begin
                rx_cnt_q <= rx_last ? 5'd0 : (rx_cnt_q == 5'(`DCA_REQ_BYTES - 1) ? rx_cnt_q : rx_cnt_q + 5'd1);
                if (rx_last && req_ok) begin
                    tx_busy_q <= 1'b1;
                    tx_idx_q  <= 5'd0;
                    tx_data   <= req_q[0];
                    tx_last   <= 1'b0;
                    sw_snap_q <= status;
                end
            end else if (tx_step) begin
                if (tx_last) begin
                    tx_busy_q <= 1'b0;
                    tx_last   <= 1'b0;
                end else begin
                    tx_idx_q <= tx_idx_q + 5'd1;
                    tx_data  <= rsp_byte(tx_idx_q + 5'd1, sw_snap_q);
                    tx_last  <= (tx_idx_q == 5'(`DCA_RSP_BYTES - 2));
                end
            end
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    sequence s_setup_walk;
        (st_q == dca_pkg::ST_FWD) ##1 (st_q == dca_pkg::ST_FWD || st_q == dca_pkg::ST_REV);
    endsequence
    property p_port_only;
        @(posedge clk) disable iff (!nrst) ce && conn_req && !conn_close && conn_port != `DCA_TCP_PORT && !conn_q |=> !conn_q;
    endproperty
    a_port_only: assert property (p_port_only) else $error("connection taken on wrong port");
    property p_one_client;
        @(posedge clk) disable iff (!nrst) conn_q && !conn_close |=> conn_q;
    endproperty
    a_one_client: assert property (p_one_client) else $error("connection dropped without close");
    property p_no_crc;
        @(posedge clk) disable iff (!nrst) tx_valid && tx_last |-> tx_data == `DCA_RSP_TAIL && tx_idx_q == 5'd19;
    endproperty
    a_no_crc: assert property (p_no_crc) else $error("frame end not at tail byte");
    property p_len_field;
        @(posedge clk) disable iff (!nrst) tx_valid && tx_idx_q == 5'd4 |-> tx_data == `DCA_RSP_LEN;
    endproperty
    a_len_field: assert property (p_len_field) else $error("length field wrong");
    property p_start;
        @(posedge clk) disable iff (!nrst) start_go |=> s_setup_walk;
    endproperty
    a_start: assert property (p_start) else $error("auto setup did not start");
    property p_done_flag;
        @(posedge clk) disable iff (!nrst) ce && st_q == dca_pkg::ST_EDGE && step_end |=> status[`DCA_SW_DONE_BIT];
    endproperty
    a_done_flag: assert property (p_done_flag) else $error("done bit not set");
    property p_closed_loop;
        @(posedge clk) disable iff (!nrst) $rose(closed_loop_ok) |-> $past(st_q) == dca_pkg::ST_EDGE && !coord_valid;
    endproperty
    a_closed_loop: assert property (p_closed_loop) else $error("closed loop without setup");
    property p_reverse;
        @(posedge clk) disable iff (!nrst) $fell(st_q == dca_pkg::ST_FWD) |-> st_q == dca_pkg::ST_REV;
    endproperty
    a_reverse: assert property (p_reverse) else $error("reverse pass skipped");
    property p_self_addr;
        @(posedge clk) disable iff (!nrst) $rose(self_assigned_address) |-> !$past(dhcp_offer) && $past(dhcp_cnt_q) == 32'(DHCP_WAIT_CYC - 1);
    endproperty
    a_self_addr: assert property (p_self_addr) else $error("self address too early");
endmodule // dca_drive_config

// >>> tb/dca_tcp_master.sv
`timescale 1ns/100ps
module dca_tcp_master (
    input  wire logic       clk,
    input  wire logic       slow,
    input  wire logic       rx_ready,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_last,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_last,
    output logic            tx_ready
);
    // ----------------------------------------
    // statusword encapsulated read, no crc
    // ----------------------------------------
    logic [7:0] req [19] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h2b, 8'h0d, 8'h00,
                             8'h00, 8'h01, 8'h60, 8'h41, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02};
    logic [7:0] rsp [20];
    logic       rsp_last;
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_last = 1'b0;
        tx_ready = 1'b0;
    end
    // slow mode drops tx_ready every other cycle, stalling each answer byte
    always @(posedge clk) tx_ready <= slow ? ~tx_ready : 1'b1;
    task automatic send_req();
        for (int k = 0; k < 19; k++) begin
            rx_valid <= 1'b1;
            rx_data <= req[k];
            rx_last <= (k == 18);
            do @(posedge clk); while (!rx_ready);
        end
        rx_valid <= 1'b0;
        rx_data <= ~req[18];
        rx_last <= 1'b0;
        for (int n = 0; n < 20; n++) begin
            do @(posedge clk); while (!(tx_valid && tx_ready));
            rsp[n] = tx_data;
            rsp_last = tx_last;
        end
    endtask
endmodule // dca_tcp_master

// >>> tb/drive_config_autosetup_tb_top.sv
`timescale 1ns/100ps
module drive_config_autosetup_tb_top;
    logic        clk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, conn_req;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, conn_close, slow;
    logic        conn_active, rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready, self_assigned_address;
    logic        index_pulse, motor_is_bldc, brake_en, standstill_red_en, closed_loop_ok, coord_valid, dhcp_offer;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, rx_data, tx_data, e;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp, enc_sel;
    logic [15:0] conn_port;
    logic [33:0] r;
    logic [31:0] sm [4] = '{32'h8, 32'hc, 32'h41, 32'h44};
    logic [2:0]  ex [4] = '{3'h1, 3'h3, 3'h4, 3'h6};
    logic [7:0]  ofs [3] = '{8'h04, 8'h08, 8'h14};
    int          fails, num_checks, cyc;
    dca_drive_config #(.STEP_CYC(4), .DHCP_WAIT_CYC(16)) dca_drive_config_i (
        .clk, .nrst, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conn_req, .conn_close,
        .conn_port, .conn_active, .rx_valid, .rx_data, .rx_last, .rx_ready, .tx_valid, .tx_data, .tx_last,
        .tx_ready, .dhcp_offer, .self_assigned_address, .index_pulse, .motor_is_bldc, .brake_en,
        .standstill_red_en, .enc_sel, .closed_loop_ok, .coord_valid);
    dca_tcp_master dca_tcp_master_i (.clk, .slow, .rx_ready, .tx_valid, .tx_data, .tx_last, .rx_valid,
        .rx_data, .rx_last, .tx_ready);
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fails = fails + 1;
            complete_run();
        end
    end
    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge clk);
            if (s_axi_awready) begin
                ta = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready) begin
                tw = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (!s_axi_bvalid) @(posedge clk);
        chk(s_axi_bresp, 2'h0);
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic axr(input logic [7:0] a, output logic [33:0] q);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge clk);
        q = {s_axi_rresp, s_axi_rdata};
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic complete_run();
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        {clk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h00;
        {conn_req, conn_close, index_pulse, slow, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 52'h0;
        {conn_port, fails, num_checks, cyc} = 112'h0;
        dhcp_offer = 1'b1;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        axr(8'h00, r);
        chk(r, 34'h32);
        axr(8'h0c, r);
        chk(r, 34'h64);
        axr(8'h10, r);
        chk(r, 34'h8);
        axr(8'h30, r);
        chk(r[33:32], 2'h2);
        chk({closed_loop_ok, coord_valid}, 2'h1);
        chk(self_assigned_address, 1'h0);
        dhcp_offer <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            axw(ofs[k], 32'h0000_05dc + k);
            axr(ofs[k], r);
            chk(r, 34'h5dc + k);
        end
        for (int i = 0; i < 4; i++) begin
            axw(8'h10, sm[i]);
            chk({motor_is_bldc, brake_en, standstill_red_en}, ex[i]);
            axw(8'h18, i);
            chk(enc_sel, i[1:0]);
        end
        $display("test registers done");
        conn_port <= 16'h01f7;
        conn_req <= 1'b1;
        @(posedge clk);
        conn_req <= 1'b0;
        repeat (4) @(posedge clk);
        chk(conn_active, 1'h0);
        conn_port <= 16'h01f6;
        conn_req <= 1'b1;
        @(posedge clk);
        conn_req <= 1'b0;
        do @(posedge clk); while (!conn_active);
        for (int s = 0; s < 2; s++) begin
            slow <= s[0];
            dca_tcp_master_i.send_req();
            for (int n = 0; n < 20; n++) begin
                e = n < 4 ? dca_tcp_master_i.req[n] : n == 4 ? 8'h0f : n == 5 ? 8'h00 :
                    n < 17 ? dca_tcp_master_i.req[n + 1] : n == 19 ? 8'h06 : 8'h00;
                chk(dca_tcp_master_i.rsp[n], e);
            end
            chk(dca_tcp_master_i.rsp_last, 1'h1);
        end
        $display("test link done");
        index_pulse <= 1'b1;
        axw(8'h1c, 32'hfe);
        axw(8'h20, 32'h0f);
        axw(8'h20, 32'h1f);
        r = 34'h0;
        while (!r[12]) axr(8'h24, r);
        chk({r[12], r[10]}, 2'h3);
        chk({closed_loop_ok, coord_valid}, 2'h2);
        axr(8'h2c, r);
        chk(r[3:0], 4'h7);
        $display("test auto setup done");
        complete_run();
    end
endmodule // drive_config_autosetup_tb_top
